// File: verilog/pport_pkg.sv
// Constants, register indexes and types shared by the parallel port block.
// Assumes a single 100 MHz core clock and a synchronous active-low reset.
package pport_pkg;

   localparam int unsigned NUM_PORTS = 8;
   localparam int unsigned ADDR_W    = 8;
   localparam int unsigned IDX_W     = 4;

   // Register indexes; the byte address is four times the index.
   localparam logic [3:0] IDX_PORT_ZERO_LATCH  = 4'h0;
   localparam logic [3:0] IDX_PORT_ZERO_DIR    = 4'h1;
   localparam logic [3:0] IDX_PORT_ONE_LATCH   = 4'h2;
   localparam logic [3:0] IDX_PORT_ONE_DIR     = 4'h3;
   localparam logic [3:0] IDX_PORT_TWO_LATCH   = 4'h4;
   localparam logic [3:0] IDX_PORT_TWO_DIR     = 4'h5;
   localparam logic [3:0] IDX_PORT_THREE_LATCH = 4'h6;
   localparam logic [3:0] IDX_PORT_THREE_GATE  = 4'h7;
   localparam logic [3:0] IDX_PORT_FOUR_LATCH  = 4'h8;
   localparam logic [3:0] IDX_PORT_FOUR_DIR    = 4'h9;
   localparam logic [3:0] IDX_PORT_FIVE_LATCH  = 4'hA;
   localparam logic [3:0] IDX_PORT_FIVE_DIR    = 4'hB;
   localparam logic [3:0] IDX_PORT_SIX_LATCH   = 4'hC;
   localparam logic [3:0] IDX_PORT_SIX_DIR     = 4'hD;
   localparam logic [3:0] IDX_PORT_SEVEN_LATCH = 4'hE;
   localparam logic [3:0] IDX_PORT_SEVEN_DIR   = 4'hF;

   // Byte address fields.
   localparam int unsigned IDX_LSB   = 2;
   localparam int unsigned IDX_MSB   = 5;
   localparam int unsigned HIGH_LSB  = 6;

   localparam logic [2:0] PORT_ZERO  = 3'h0;
   localparam logic [2:0] PORT_ONE   = 3'h1;
   localparam logic [2:0] PORT_THREE = 3'h3;
   localparam logic [2:0] PORT_SEVEN = 3'h7;

   localparam int unsigned GROUP_BIT    = 0;
   localparam int unsigned GATE_BIT     = 0;
   localparam int unsigned ONE_GROUP_HI = 5;
   localparam int unsigned SEVEN_OWN_LO = 1;

   localparam logic [7:0] LATCH_RST   = 8'h00;
   localparam logic [7:0] DIR_RST     = 8'h00;
   localparam logic [7:0] GATE_RST    = 8'h00;
   localparam logic [7:0] GATE_MASK   = 8'h01;
   localparam logic [7:0] FULL_MASK   = 8'hFF;
   localparam logic [7:0] SEVEN_IN_LO = 8'h01;
   localparam logic [23:0] RD_PAD     = 24'h00_0000;
   localparam logic [7:0] UNMAPPED_RD = 8'h00;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'h1,
      BUS_ACK  = 2'h2
   } bus_state_e;

endpackage

// File: verilog/pport_reg_if.sv
// Internal register access carrier between the bus slave and the port core.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
`default_nettype none
interface pport_reg_if;
   logic       wr_stb;
   logic       rd_stb;
   logic [3:0] index;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport bus_side (output wr_stb, output rd_stb, output index, output wdata, input rdata);
   modport core_side (input wr_stb, input rd_stb, input index, input wdata, output rdata);
endinterface
`default_nettype wire

// File: verilog/pin_sync.sv
// Two-stage synchroniser for the port pin levels.
// Assumes pins change without regard to the core clock.
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
   input  wire logic            core_clk,
   input  wire logic            rstn,
   input  wire logic [7:0][7:0] pin_raw,
   output logic      [7:0][7:0] pin_safe
);
   logic [7:0][7:0] stage_one_reg;

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         stage_one_reg <= '0;
         pin_safe      <= '0;
      end else begin
         stage_one_reg <= pin_raw;
         pin_safe      <= stage_one_reg;
      end
   end
endmodule
`default_nettype wire

// File: verilog/avalon_slave.sv
// Avalon-MM slave front end: one wait cycle, then a single-cycle answer.
// Assumes the master holds address, direction and data until waitrequest is low.
`timescale 1ns/100ps
`default_nettype none
module avalon_slave (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   pport_reg_if.bus_side    regs
);
   pport_pkg::bus_state_e state_reg;
   logic                  mapped;

   // Only word-aligned addresses inside the sixteen-word window are decoded.
   always_comb begin
      if (avs_address[pport_pkg::HIGH_LSB +: 2] != 2'h0) begin
         mapped = 1'b0;
      end else if (avs_address[1:0] != 2'h0) begin
         mapped = 1'b0;
      end else begin
         mapped = 1'b1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         state_reg <= pport_pkg::BUS_IDLE;
      end else begin
         case (state_reg)
            pport_pkg::BUS_IDLE: begin
               if (avs_read || avs_write) begin
                  state_reg <= pport_pkg::BUS_ACK;
               end
            end
            default: begin
               state_reg <= pport_pkg::BUS_IDLE;
            end
         endcase
      end
   end

   // Read data is captured during the wait cycle so it stands at the acknowledge edge.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         avs_readdata <= '0;
      end else if (state_reg == pport_pkg::BUS_IDLE && avs_read) begin
         avs_readdata <= {pport_pkg::RD_PAD, mapped ? regs.rdata : pport_pkg::UNMAPPED_RD};
      end
   end

   assign avs_waitrequest = (avs_read || avs_write) && (state_reg == pport_pkg::BUS_IDLE);
   assign regs.index      = avs_address[pport_pkg::IDX_MSB:pport_pkg::IDX_LSB];
   assign regs.wdata      = avs_writedata[7:0];
   assign regs.rd_stb     = avs_read && (state_reg == pport_pkg::BUS_ACK) && mapped;
   assign regs.wr_stb     = avs_write && avs_byteenable[0] && (state_reg == pport_pkg::BUS_ACK)
                            && mapped;
endmodule
`default_nettype wire

// File: verilog/parallel_port_direction_ctrl.sv
// Top of the parallel port block: data latches, direction and gate registers,
// pin drivers and read-back multiplexing, reached over Avalon-MM.
// Assumes pin levels come from outside the core clock domain and that the
// pad ring resolves the wire from pin_out, pin_oe_n and port_three_pullup.
`timescale 1ns/100ps
`default_nettype none
module parallel_port_direction_ctrl (
   input  wire logic            core_clk,
   input  wire logic            rstn,
   input  wire logic [7:0]      avs_address,
   input  wire logic            avs_read,
   input  wire logic            avs_write,
   input  wire logic [31:0]     avs_writedata,
   input  wire logic [3:0]      avs_byteenable,
   output logic      [31:0]     avs_readdata,
   output logic                 avs_waitrequest,
   input  wire logic [7:0][7:0] pin_in,
   output logic      [7:0][7:0] pin_out,
   output logic      [7:0][7:0] pin_oe_n,
   output logic                 port_three_pullup
);

   ////////////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Turns a port's direction register into one output flag per pin.
   function automatic logic [7:0] pin_dir(input logic [2:0] port, input logic [7:0] ctl);
      logic [7:0] d;
      d = ctl;
      case (port)
         pport_pkg::PORT_ZERO: begin
            d = {8{ctl[pport_pkg::GROUP_BIT]}};
         end
         pport_pkg::PORT_ONE: begin
            d = {ctl[7:pport_pkg::ONE_GROUP_HI + 1],
                 {(pport_pkg::ONE_GROUP_HI + 1){ctl[pport_pkg::GROUP_BIT]}}};
         end
         pport_pkg::PORT_THREE: begin
            d = {8{ctl[pport_pkg::GATE_BIT]}};
         end
         pport_pkg::PORT_SEVEN: begin
            d = ctl & ~pport_pkg::SEVEN_IN_LO;
         end
         default: begin
            d = ctl;
         end
      endcase
      return d;
   endfunction

   // Port 3 has no input path, so its data read shows the latch on every bit.
   function automatic logic [7:0] read_from_latch(input logic [2:0] port, input logic [7:0] d);
      logic [7:0] m;
      m = (port == pport_pkg::PORT_THREE) ? pport_pkg::FULL_MASK : d;
      return m;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Bus front end and pin synchroniser.

   pport_reg_if     reg_bus ();
   logic [7:0][7:0] pin_safe;
   logic [7:0]      latch_reg [pport_pkg::NUM_PORTS];
   logic [7:0]      ctl_reg   [pport_pkg::NUM_PORTS];
   logic [7:0][7:0] dir_eff;
   logic [2:0]      acc_port;
   logic            acc_is_ctl;

   avalon_slave u_bus (
      .core_clk        (core_clk),
      .rstn            (rstn),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .regs            (reg_bus.bus_side)
   );

   pin_sync u_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .pin_raw  (pin_in),
      .pin_safe (pin_safe)
   );

   // Even index is a data latch, odd index the direction or gate register.
   assign acc_port   = reg_bus.index[3:1];
   assign acc_is_ctl = reg_bus.index[0];

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.

   // Latches take writes whatever the direction, so output data can be staged
   // before a pin is turned round.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         for (int p = 0; p < pport_pkg::NUM_PORTS; p++) begin
            latch_reg[p] <= pport_pkg::LATCH_RST;
         end
      end else if (reg_bus.wr_stb && !acc_is_ctl) begin
         latch_reg[acc_port] <= reg_bus.wdata;
      end
   end

   // Direction registers keep all eight written bits; the gate keeps bit 0 only.
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         for (int p = 0; p < pport_pkg::NUM_PORTS; p++) begin
            ctl_reg[p] <= pport_pkg::DIR_RST;
         end
      end else if (reg_bus.wr_stb && acc_is_ctl) begin
         if (acc_port == pport_pkg::PORT_THREE) begin
            ctl_reg[acc_port] <= reg_bus.wdata & pport_pkg::GATE_MASK;
         end else begin
            ctl_reg[acc_port] <= reg_bus.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin drivers.

   always_comb begin
      for (int p = 0; p < pport_pkg::NUM_PORTS; p++) begin
         dir_eff[p] = pin_dir(3'(p), ctl_reg[p]);
      end
   end

   // Driven from flops only; an undriven pin keeps its enable high.
   always_comb begin
      for (int p = 0; p < pport_pkg::NUM_PORTS; p++) begin
         pin_out[p]  = latch_reg[p];
         pin_oe_n[p] = ~dir_eff[p];
      end
   end

   assign port_three_pullup = ~ctl_reg[pport_pkg::PORT_THREE][pport_pkg::GATE_BIT];

   ////////////////////////////////////////////////////////////////////////////////
   // Read-back.

   always_comb begin
      logic [7:0] m;
      m = read_from_latch(acc_port, dir_eff[acc_port]);
      if (acc_is_ctl) begin
         reg_bus.rdata = ctl_reg[acc_port];
      end else begin
         reg_bus.rdata = (latch_reg[acc_port] & m) | (pin_safe[acc_port] & ~m);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   // The expected data read is built from what the pins show, not from the
   // read mux, so a wrong mux select cannot hide behind its own copy.
   logic [7:0] exp_rd;
   logic [7:0] exp_mask;
   logic       addr_outside;
   always_comb begin
      exp_mask = ~pin_oe_n[acc_port];
      if (acc_port == pport_pkg::PORT_THREE) begin
         exp_mask = pport_pkg::FULL_MASK;
      end
      exp_rd = (pin_out[acc_port] & exp_mask) | (pin_safe[acc_port] & ~exp_mask);
   end

   // Requests outside the sixteen-word window must leave every register alone.
   assign addr_outside = avs_address[7:6] != 2'h0 || avs_address[1:0] != 2'h0;

   dir_group_zero_a: assert property (@(posedge core_clk) disable iff (!rstn)
      pin_oe_n[0] == {8{~ctl_reg[0][0]}})
      else $error("port zero pins do not follow the group bit");

   dir_group_one_a: assert property (@(posedge core_clk) disable iff (!rstn)
      pin_oe_n[1][5:0] == {6{~ctl_reg[1][0]}})
      else $error("port one low pins do not follow the group bit");

   dir_own_bits_a: assert property (@(posedge core_clk) disable iff (!rstn)
      pin_oe_n[1][7:6] == ~ctl_reg[1][7:6] && pin_oe_n[4] == ~ctl_reg[4]
      && pin_oe_n[5] == ~ctl_reg[5] && pin_oe_n[6] == ~ctl_reg[6]
      && pin_oe_n[7][7:1] == ~ctl_reg[7][7:1])
      else $error("individually steered pins do not follow their bits");

   dir_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_bus.wr_stb && acc_is_ctl && acc_port == 3'h4 |=>
      pin_oe_n[4] == ~$past(reg_bus.wdata))
      else $error("port four drivers not set by written direction");

   gate_drivers_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_bus.wr_stb && acc_is_ctl && acc_port == 3'h3 |=>
      pin_oe_n[3] == {8{~$past(reg_bus.wdata[0])}} && pin_out[3] == latch_reg[3])
      else $error("port three drivers not gated by bit 0");

   reset_gate_a: assert property (@(posedge core_clk)
      !rstn |=> port_three_pullup && pin_oe_n[3] == 8'hFF)
      else $error("port three driven after reset");

   reset_dir_a: assert property (@(posedge core_clk)
      !rstn |=> pin_oe_n == {64{1'b1}})
      else $error("a pin is driven right after reset");

   input_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_bus.wr_stb && !acc_is_ctl && acc_port == 3'h5 && ctl_reg[5] == 8'h00 |=>
      pin_oe_n[5] == 8'hFF && latch_reg[5] == $past(reg_bus.wdata))
      else $error("write to input pins drove them or missed the latch");

   read_data_a: assert property (@(posedge core_clk) disable iff (!rstn)
      avs_read && !avs_waitrequest && avs_address[7:6] == 2'h0 && avs_address[1:0] == 2'h0
      && !avs_address[2] |-> avs_readdata[7:0] == $past(exp_rd))
      else $error("data read mixes latch and pin wrongly");

   read_ctl_a: assert property (@(posedge core_clk) disable iff (!rstn)
      avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == 8'h24 ##2
      avs_read && avs_address == 8'h24 ##1 avs_read && !avs_waitrequest |->
      avs_readdata[7:0] == $past(avs_writedata[7:0], 3))
      else $error("direction register does not read back its write");

   wait_bound_a: assert property (@(posedge core_clk) disable iff (!rstn)
      avs_waitrequest |=> !avs_waitrequest)
      else $error("waitrequest held longer than one cycle");

   ////////////////////////////////////////////////////////////////////////////////
   // Driver, read-back and bus checks.

   seven_low_pin_a: assert property (@(posedge core_clk) disable iff (!rstn)
      pin_oe_n[7][0])
      else $error("port seven pin zero is driven");

   port_two_own_a: assert property (@(posedge core_clk) disable iff (!rstn)
      pin_oe_n[2] == ~ctl_reg[2])
      else $error("port two pins do not follow their own bits");

   pullup_follow_a: assert property (@(posedge core_clk) disable iff (!rstn)
      port_three_pullup == pin_oe_n[3][0])
      else $error("port three pull-up does not track its drivers");

   group_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_bus.wr_stb && acc_is_ctl && acc_port == 3'h0 |=>
      pin_oe_n[0] == {8{~$past(reg_bus.wdata[0])}})
      else $error("port zero drivers not set by the group bit");

   one_group_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_bus.wr_stb && acc_is_ctl && acc_port == 3'h1 |=>
      pin_oe_n[1][5:0] == {6{~$past(reg_bus.wdata[0])}})
      else $error("port one low drivers not set by the group bit");

   latch_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !(reg_bus.wr_stb && !acc_is_ctl) |=> $stable(pin_out))
      else $error("a latch changed without a data write");

   dir_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
      !(reg_bus.wr_stb && acc_is_ctl) |=> $stable(pin_oe_n))
      else $error("a driver changed without a direction write");

   reset_latch_a: assert property (@(posedge core_clk)
      !rstn |=> pin_out == 64'h0000_0000_0000_0000)
      else $error("a latch is not cleared by reset");

   reset_bus_a: assert property (@(posedge core_clk)
      !rstn |=> avs_readdata == 32'h0000_0000)
      else $error("read data is not cleared by reset");

   read_port_three_a: assert property (@(posedge core_clk) disable iff (!rstn)
      avs_read && !avs_waitrequest && avs_address == 8'h18 |->
      avs_readdata[7:0] == $past(pin_out[3]))
      else $error("port three data read does not return its latch");

   read_gate_a: assert property (@(posedge core_clk) disable iff (!rstn)
      avs_read && !avs_waitrequest && avs_address == 8'h1C |->
      avs_readdata[7:1] == 7'h00 && avs_readdata[0] == ~port_three_pullup)
      else $error("gate register reads back more than its enable bit");

   seven_read_pin_a: assert property (@(posedge core_clk) disable iff (!rstn)
      avs_read && !avs_waitrequest && avs_address == 8'h38 |->
      avs_readdata[0] == $past(pin_safe[7][0]))
      else $error("port seven pin zero read does not show the pin");

   read_pad_a: assert property (@(posedge core_clk) disable iff (!rstn)
      avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
      else $error("upper read lanes are not zero");

   outside_read_a: assert property (@(posedge core_clk) disable iff (!rstn)
      avs_read && !avs_waitrequest && addr_outside |-> avs_readdata == 32'h0000_0000)
      else $error("read outside the window returned data");

   outside_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      avs_write && addr_outside |-> !reg_bus.wr_stb)
      else $error("write outside the window reached a register");

   lane_write_a: assert property (@(posedge core_clk) disable iff (!rstn)
      avs_write && !avs_byteenable[0] |-> !reg_bus.wr_stb)
      else $error("write without the low byte lane reached a register");

   wait_first_a: assert property (@(posedge core_clk) disable iff (!rstn)
      $rose(avs_read || avs_write) |-> avs_waitrequest)
      else $error("a new request was answered without its wait cycle");

   strobe_ack_a: assert property (@(posedge core_clk) disable iff (!rstn)
      reg_bus.wr_stb || reg_bus.rd_stb |-> !avs_waitrequest)
      else $error("a register strobe fired outside the answer cycle");

endmodule
`default_nettype wire

// File: dv/pin_field_model.sv
// Model of the circuitry on the port pins: weak sources that set a level
// wherever the block leaves a pin undriven.
// Assumes the block drives pin_out wherever pin_oe_n is low.
`timescale 1ns/100ps
`default_nettype none
module pin_field_model (
   input  wire logic [7:0][7:0] pin_out,
   input  wire logic [7:0][7:0] pin_oe_n,
   input  wire logic            port_three_pullup,
   input  wire logic [7:0][7:0] ext_level,
   output logic      [7:0][7:0] pin_level
);
   // The external sources are weak, so a driving pin always wins.
   always_comb begin
      for (int p = 0; p < 8; p++) begin
         for (int b = 0; b < 8; b++) begin
            if (pin_oe_n[p][b] == 1'b0) begin
               pin_level[p][b] = pin_out[p][b];
            end else if (p == 3 && port_three_pullup == 1'b1) begin
               pin_level[p][b] = 1'b1;
            end else begin
               pin_level[p][b] = ext_level[p][b];
            end
         end
      end
   end
endmodule
`default_nettype wire

// File: dv/test_parallel_port_direction_ctrl.sv
// Self-checking bench for the parallel port block over Avalon-MM.
// Assumes the pin field model supplies every level the block samples.
`timescale 1ns/100ps
`default_nettype none
module test_parallel_port_direction_ctrl;
   logic            core_clk;
   logic            rstn;
   logic [7:0]      avs_address;
   logic            avs_read;
   logic            avs_write;
   logic [31:0]     avs_writedata;
   logic [3:0]      avs_byteenable;
   logic [31:0]     avs_readdata;
   logic            avs_waitrequest;
   logic [7:0][7:0] pin_in;
   logic [7:0][7:0] pin_out;
   logic [7:0][7:0] pin_oe_n;
   logic            port_three_pullup;
   logic [7:0][7:0] ext_level;
   logic [63:0]     rd;
   int              err_total;
   int              total_checks;
   int              cycles = 0;

   // The external level opposes the first latch pattern in every bit.
   localparam logic [7:0] EXT_VAL   = 8'h3C;
   localparam int         CYC_LIMIT = 3000;

   parallel_port_direction_ctrl DUT (
      .core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .port_three_pullup(port_three_pullup)
   );

   pin_field_model field (
      .pin_out(pin_out), .pin_oe_n(pin_oe_n), .port_three_pullup(port_three_pullup),
      .ext_level(ext_level), .pin_level(pin_in)
   );

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [63:0] wide(input logic [7:0] v);
      return {56'h00_0000_0000_0000, v};
   endfunction

   // Only defined register words come from here; no reserved location is written.
   function automatic logic [7:0] reg_addr(input int idx);
      return 8'(idx * 4);
   endfunction

   // Pins that drive for a given direction value; for port 3 it is the gate.
   function automatic logic [7:0] drive_mask(input int p, input logic [7:0] d);
      case (p)
         0, 3: return {8{d[0]}};
         1: return {d[7:6], {6{d[0]}}};
         7: return {d[7:1], 1'b0};
         default: return d;
      endcase
   endfunction

   // One transfer; the request stands until a rising edge samples waitrequest
   // low, and read data is taken and the request dropped at that same edge.
   task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data);
      @(posedge core_clk);
      avs_address   <= addr;
      avs_writedata <= {24'h00_0000, data};
      avs_write     <= wr;
      avs_read      <= ~wr;
      @(posedge core_clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge core_clk);
      end
      rd = {32'h0000_0000, avs_readdata};
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
   endtask

   // Port 7 pin 0 has no driver, so its pin_out bit is not compared.
   task automatic pins(input int p, input logic [7:0] m, input logic [7:0] l);
      logic [7:0] keep;
      keep = (p == 7) ? 8'hFE : 8'hFF;
      @(negedge core_clk);
      check(wide(pin_oe_n[p]), wide(~m));
      check(wide(pin_out[p] & keep), wide(l & keep));
   endtask

   // Extra edges after release let the pin synchroniser refill.
   task automatic do_reset();
      repeat (3) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge core_clk);
   endtask

   task automatic reset_check();
      for (int i = 0; i < 16; i++) begin
         bus(1'b0, reg_addr(i), 8'h00);
         check(rd, wide((i % 2 == 1 || i == 6) ? 8'h00 : EXT_VAL));
      end
      @(negedge core_clk);
      check({63'h0, port_three_pullup}, 64'h1);
      check(pin_oe_n, {64{1'b1}});
      check(pin_out, 64'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == CYC_LIMIT) begin
         err_total++;
         end_sim();
      end
   end

   initial begin
      logic [7:0] d;
      logic [7:0] m;
      logic [7:0] l;
      rstn = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0000_0000;
      avs_byteenable = 4'hF;
      ext_level = {8{EXT_VAL}};
      err_total = 0;
      total_checks = 0;
      do_reset();
      reset_check();
      // Bit 0 set, then only bit 0 clear, so grouped and single pins split.
      // The latch goes first, so the first one lands while every pin of that port is an input.
      for (int p = 0; p < 8; p++) begin
         for (int k = 0; k < 2; k++) begin
            d = (k == 0) ? 8'h01 : 8'hFE;
            l = (k == 0) ? 8'hC3 : 8'hD2;
            m = drive_mask(p, d);
            bus(1'b1, reg_addr(2 * p), l);
            if (k == 0) begin
               pins(p, 8'h00, l);
            end
            bus(1'b1, reg_addr(2 * p + 1), d);
            bus(1'b0, reg_addr(2 * p + 1), 8'h00);
            check(rd, wide((p == 3) ? {7'h00, d[0]} : d));
            bus(1'b0, reg_addr(2 * p), 8'h00);
            check(rd, wide((p == 3) ? l : ((m & l) | (~m & EXT_VAL))));
            pins(p, m, l);
            if (p == 3) begin
               check({63'h0, port_three_pullup}, {63'h0, ~d[0]});
            end
         end
      end
      // Outside the window nothing is stored and reads give zero.
      bus(1'b1, 8'h45, 8'h01);
      bus(1'b0, 8'h40, 8'h00);
      check(rd, wide(8'h00));
      bus(1'b0, 8'h03, 8'h00);
      check(rd, wide(8'h00));
      avs_byteenable <= 4'hE;
      bus(1'b1, reg_addr(1), 8'h01);
      avs_byteenable <= 4'hF;
      bus(1'b0, reg_addr(1), 8'h00);
      check(rd, wide(8'hFE));
      rstn <= 1'b0;
      do_reset();
      reset_check();
      end_sim();
   end
endmodule
`default_nettype wire
